// *** include/cmpst_pkg.sv ***
// package: register map, field positions and reset values of the comparator status block
package cmpst_pkg;
   // ==========================================================
   // register offsets (byte addresses)
   localparam logic [7:0] CMPST_STATUS_OFS = 8'h00; // comparator_status word
   localparam logic [7:0] CMPST_CTRL_OFS = 8'h04; // per-channel polarity and edge control
   localparam logic [7:0] CMPST_IRQ_STAT_OFS = 8'h08; // sticky event flags, write one to clear
   localparam logic [7:0] CMPST_IRQ_MASK_OFS = 8'h0C; // interrupt enable mask
   localparam logic [7:0] CMPST_EVT_CLR_OFS = 8'h10; // write one to clear a channel event latch
   // ==========================================================
   // field positions inside comparator_status
   localparam int CMPST_IDLE_STOP_BIT = 15; // idle_stop_all
   localparam int CMPST_EVT_LSB = 8; // chan1_event_status .. chan4 at 11
   localparam int CMPST_OUT_LSB = 0; // chan1_output_status .. chan4 at 3
   // control register layout: channel n uses bits 4n+3..4n
   localparam int CMPST_CTRL_INV = 0; // output_invert_select
   localparam int CMPST_CTRL_EDGE_LSB = 1; // event_edge_select, two bits
   localparam int CMPST_CTRL_ENABLE = 3; // channel enable
   // ==========================================================
   // counts and reset values
   localparam int CMPST_NCHAN = 4;
   localparam logic [15:0] CMPST_STATUS_RST = 16'h0000;
   localparam logic [15:0] CMPST_CTRL_RST = 16'h0000;
   localparam logic [3:0] CMPST_NIBBLE_RST = 4'h0;
   // ==========================================================
   // edge select encodings
   localparam logic [1:0] CMPST_EDGE_OFF = 2'h0;
   localparam logic [1:0] CMPST_EDGE_RISE = 2'h1;
   localparam logic [1:0] CMPST_EDGE_FALL = 2'h2;
   localparam logic [1:0] CMPST_EDGE_ANY = 2'h3;
   // ahb transfer type
   localparam logic [1:0] CMPST_HTRANS_NONSEQ = 2'h2;
endpackage : cmpst_pkg

// *** src/cmpst_channel.sv ***
// one comparator channel: pin synchroniser, polarity, edge detect and event latch
`timescale 1ns/100ps
`default_nettype none
module cmpst_channel
   import cmpst_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // analog comparator raw result
   input wire logic cmp_raw,
   // control
   input wire logic enable,
   input wire logic output_invert_select,
   input wire logic [1:0] event_edge_select,
   input wire logic event_clear,
   // status
   output logic channel_result_bit,
   output logic channel_event_latch,
   output logic event_pulse
);
   // all channel state
   typedef struct packed {
      logic [2:0] sync; // three-stage pin synchroniser
      logic result; // polarity-applied result
      logic latch; // event latch
      logic pulse; // one-cycle event strobe
   } cmpst_chan_type;
   cmpst_chan_type state, next_state;
   logic agreed; // stage two and three agree
   logic new_res; // candidate result
   logic rise, fall, hit;

   // next state
   always_comb begin
      next_state = state;
      next_state.sync = {state.sync[1:0], cmp_raw};
      agreed = (state.sync[1] == state.sync[2]);
      new_res = state.result;
      if (enable && agreed) begin
         new_res = state.sync[2] ^ output_invert_select;
      end
      next_state.result = new_res;
      rise = !state.result && new_res;
      fall = state.result && !new_res;
      unique case (event_edge_select)
         CMPST_EDGE_OFF: hit = 1'b0;
         CMPST_EDGE_RISE: hit = rise;
         CMPST_EDGE_FALL: hit = fall;
         CMPST_EDGE_ANY: hit = rise | fall;
      endcase
      hit = hit && enable && !state.latch; // latch blocks triggers
      next_state.pulse = hit;
      if (hit) begin
         next_state.latch = 1'b1; // set wins over clear
      end else if (event_clear) begin
         next_state.latch = 1'b0;
      end
   end

   // register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign channel_result_bit = state.result;
   assign channel_event_latch = state.latch;
   assign event_pulse = state.pulse;

   a_latch_holds: assert property (@(posedge hclk) disable iff (!hresetn)
      state.latch && !event_clear |=> state.latch)
      else $error("event latch dropped without clear");
   a_pulse_sets_latch: assert property (@(posedge hclk) disable iff (!hresetn)
      state.pulse |-> state.latch && !$past(state.latch))
      else $error("event pulse without fresh latch");
endmodule : cmpst_channel
`default_nettype wire

// *** src/cmpst_top.sv ***
// comparator status collector: ahb-lite slave, four channels, interrupt
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - idle-stop set halts all channels in idle
// - bits 11..8 mirror channel event latches
// - bits 3..0 mirror channel result bits
// - result is one when plus exceeds minus, invertible
// - bits 14..12 and 7..4 read zero
// - reset clears every implemented bit
// - selected edge sets latch; latch blocks retrigger
module cmpst_top
   import cmpst_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // device power state and comparators
   input wire logic idle_mode,
   input wire logic [3:0] cmp_raw,
   // interrupt
   output logic irq
);
   // ==========================================================
   // state
   typedef struct packed {
      logic idle_stop_all; // writable bit 15
      logic [15:0] ctrl; // per-channel control nibbles
      logic [3:0] irq_stat; // sticky event flags
      logic [3:0] irq_mask; // interrupt mask
      logic [3:0] evt_clr; // one-cycle latch clear strobes
      logic wr_pend; // data phase of a write
      logic [7:0] wr_addr; // captured write address
      logic [31:0] rdata; // read data
      logic irq; // registered interrupt
      logic idle_sync1, idle_sync2, idle_sync3; // idle input synchroniser
      logic idle; // filtered idle level
   } cmpst_top_type;
   cmpst_top_type state, next_state;

   // channel wires
   logic [3:0] res_bits; // channel_result_bit per channel
   logic [3:0] evt_bits; // channel_event_latch per channel
   logic [3:0] evt_pulse; // new events
   logic [3:0] chan_en; // channel running
   logic [15:0] status_word; // assembled comparator_status
   logic take; // address phase accepted

   // read mux of one register, unmapped reads zero
   function automatic logic [31:0] read_reg(input logic [7:0] a, input cmpst_top_type s,
      input logic [15:0] st);
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         CMPST_STATUS_OFS: v = {16'h0000, st};
         CMPST_CTRL_OFS: v = {16'h0000, s.ctrl};
         CMPST_IRQ_STAT_OFS: v = {28'h000_0000, s.irq_stat};
         CMPST_IRQ_MASK_OFS: v = {28'h000_0000, s.irq_mask};
         default: v = 32'h0000_0000;
      endcase
      return v;
   endfunction : read_reg

   // ==========================================================
   // channels
   genvar g;
   generate
      for (g = 0; g < CMPST_NCHAN; g++) begin : gen_chan
         // idle with idle-stop set halts every channel
         assign chan_en[g] = state.ctrl[4*g+CMPST_CTRL_ENABLE]
            && !(state.idle && state.idle_stop_all);
         cmpst_channel cmpst_channel_i (
            .hclk(hclk),
            .hresetn(hresetn),
            .cmp_raw(cmp_raw[g]),
            .enable(chan_en[g]),
            .output_invert_select(state.ctrl[4*g+CMPST_CTRL_INV]),
            .event_edge_select(state.ctrl[4*g+CMPST_CTRL_EDGE_LSB +: 2]),
            .event_clear(state.evt_clr[g]),
            .channel_result_bit(res_bits[g]),
            .channel_event_latch(evt_bits[g]),
            .event_pulse(evt_pulse[g])
         );
      end
   endgenerate

   // status word: zero fill in unimplemented positions
   assign status_word = {state.idle_stop_all, 3'h0, evt_bits, 4'h0, res_bits};
   assign take = hsel && hready && (htrans == CMPST_HTRANS_NONSEQ);

   // ==========================================================
   // next state
   always_comb begin
      next_state = state;
      next_state.evt_clr = CMPST_NIBBLE_RST;
      // idle synchroniser, change accepted once stages two and three agree
      next_state.idle_sync1 = idle_mode;
      next_state.idle_sync2 = state.idle_sync1;
      next_state.idle_sync3 = state.idle_sync2;
      if (state.idle_sync2 == state.idle_sync3) begin
         next_state.idle = state.idle_sync3;
      end
      // address phase
      next_state.wr_pend = 1'b0;
      if (take) begin
         next_state.wr_pend = hwrite;
         next_state.wr_addr = {haddr[7:2], 2'b00};
         next_state.rdata = hwrite ? 32'h0000_0000 : read_reg({haddr[7:2], 2'b00}, state,
            status_word);
      end
      // sticky flags: clear first, set wins
      if (state.wr_pend) begin
         unique case (state.wr_addr)
            CMPST_STATUS_OFS: begin
               // only idle-stop is writable
               next_state.idle_stop_all = hwdata[CMPST_IDLE_STOP_BIT];
            end
            CMPST_CTRL_OFS: next_state.ctrl = hwdata[15:0];
            CMPST_IRQ_STAT_OFS: next_state.irq_stat = state.irq_stat & ~hwdata[3:0];
            CMPST_IRQ_MASK_OFS: next_state.irq_mask = hwdata[3:0];
            CMPST_EVT_CLR_OFS: next_state.evt_clr = hwdata[3:0];
            default: ;
         endcase
      end
      next_state.irq_stat = next_state.irq_stat | evt_pulse;
      next_state.irq = |(next_state.irq_stat & next_state.irq_mask);
   end

   // register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // outputs
   assign hrdata = state.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign irq = state.irq;

   // ==========================================================
   // checks
   sequence s_status_read;
      take && !hwrite && ({haddr[7:2], 2'b00} == CMPST_STATUS_OFS);
   endsequence
   a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      s_status_read |=> (hrdata[14:12] == 3'h0) && (hrdata[7:4] == 4'h0))
      else $error("reserved status bits not zero");
   a_evt_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
      s_status_read |=> hrdata[11:8] == $past(evt_bits))
      else $error("event bits do not mirror latches");
   a_out_mirror: assert property (@(posedge hclk) disable iff (!hresetn)
      s_status_read |=> hrdata[3:0] == $past(res_bits))
      else $error("output bits do not mirror results");
   a_idle_halt: assert property (@(posedge hclk) disable iff (!hresetn)
      state.idle && state.idle_stop_all |-> chan_en == 4'h0)
      else $error("channel runs in idle with stop set");
   a_idle_run: assert property (@(posedge hclk) disable iff (!hresetn)
      !state.idle_stop_all |-> chan_en[0] == state.ctrl[CMPST_CTRL_ENABLE])
      else $error("idle stopped channel with stop clear");
   a_ro_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
      state.wr_pend && state.wr_addr == CMPST_STATUS_OFS && evt_pulse == 4'h0
      && state.evt_clr == 4'h0 |=> (evt_bits & ~evt_pulse) == $past(evt_bits))
      else $error("status write altered event bits");
   a_idle_write: assert property (@(posedge hclk) disable iff (!hresetn)
      state.wr_pend && state.wr_addr == CMPST_STATUS_OFS
      |=> state.idle_stop_all == $past(hwdata[CMPST_IDLE_STOP_BIT]))
      else $error("idle stop bit not written");
   // level interrupt agrees with the stored flags and mask in every cycle
   a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
      irq == |(state.irq_stat & state.irq_mask))
      else $error("irq does not follow masked status");
endmodule : cmpst_top
`default_nettype wire

// *** tb/tb_cmpst_top.sv ***
// self-checking bench of the comparator status collector over ahb-lite
`timescale 1ns/100ps
`default_nettype none
module tb_cmpst_top
   import cmpst_pkg::*;
;
   // ==========================================================
   // stimulus and observation signals
   logic hclk = 1'b0; // bus clock, 4 ns period
   logic hresetn = 1'b0; // active low reset
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic idle_mode = 1'b0; // device idle level
   logic [3:0] cmp_raw = 4'h0; // raw comparator results
   logic irq;
   int error_cnt = 0; // mismatches
   int checks = 0; // comparisons made
   int cyc = 0; // cycle counter for the timeout
   logic [31:0] rd; // last read word
   // ==========================================================
   // design under test, hready fed back from hreadyout
   cmpst_top cmpst_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .idle_mode(idle_mode),
      .cmp_raw(cmp_raw), .irq(irq));
   // clock generator
   always #2 hclk = ~hclk;
   // hang guard
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         print_verdict();
      end
   end
   // ==========================================================
   // helpers: closing report, compares, bus cycles
   task automatic print_verdict();
      $display("counts: %0d checks, %0d errors", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : print_verdict
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: word got %h expected %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: bit got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc_wait
   // address phase held until hready, then data phase until hready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= CMPST_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk_word(rd, exp);
   endtask : rd_chk
   // quiet channels: edges off, inputs low, latches and flags cleared
   task automatic settle();
      wr(CMPST_CTRL_OFS, 32'h0000_8888);
      cmp_raw <= 4'h0;
      cyc_wait(8);
      wr(CMPST_EVT_CLR_OFS, 32'h0000_000F);
      wr(CMPST_IRQ_STAT_OFS, 32'h0000_000F);
   endtask : settle
   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd_chk(CMPST_STATUS_OFS, 32'h0000_0000);
      rd_chk(CMPST_CTRL_OFS, 32'h0000_0000);
      rd_chk(8'h14, 32'h0000_0000);
      chk_bit(irq, 1'b0);
      chk_bit(hresp, 1'b0);
      chk_bit(hreadyout, 1'b1);
      $display("test reset done");
   endtask : t_reset
   task automatic t_write_mask();
      wr(CMPST_STATUS_OFS, 32'hFFFF_FFFF);
      rd_chk(CMPST_STATUS_OFS, 32'h0000_8000);
      wr(CMPST_STATUS_OFS, 32'h0000_0000);
      rd_chk(CMPST_STATUS_OFS, 32'h0000_0000);
      $display("test write mask done");
   endtask : t_write_mask
   task automatic t_result();
      wr(CMPST_CTRL_OFS, 32'h0000_8888);
      cmp_raw <= 4'h5;
      cyc_wait(8);
      rd_chk(CMPST_STATUS_OFS, 32'h0000_0005);
      wr(CMPST_CTRL_OFS, 32'h0000_9999);
      cyc_wait(8);
      rd_chk(CMPST_STATUS_OFS, 32'h0000_000A);
      $display("test result done");
   endtask : t_result
   // ch1 rise, ch2 fall, ch3 any, ch4 off
   task automatic t_events();
      settle();
      wr(CMPST_CTRL_OFS, 32'h0000_8ECA);
      cmp_raw <= 4'hF;
      cyc_wait(8);
      rd_chk(CMPST_STATUS_OFS, 32'h0000_050F);
      cmp_raw <= 4'h0;
      cyc_wait(8);
      rd_chk(CMPST_STATUS_OFS, 32'h0000_0700);
      wr(CMPST_STATUS_OFS, 32'h0000_0000);
      rd_chk(CMPST_STATUS_OFS, 32'h0000_0700);
      rd_chk(CMPST_IRQ_STAT_OFS, 32'h0000_0007);
      wr(CMPST_IRQ_STAT_OFS, 32'h0000_000F);
      cmp_raw <= 4'hF;
      cyc_wait(8);
      cmp_raw <= 4'h0;
      cyc_wait(8);
      rd_chk(CMPST_IRQ_STAT_OFS, 32'h0000_0000);
      wr(CMPST_EVT_CLR_OFS, 32'h0000_0001);
      // clear strobe reaches the latch one edge after the data phase
      cyc_wait(2);
      rd_chk(CMPST_STATUS_OFS, 32'h0000_0600);
      $display("test events done");
   endtask : t_events
   task automatic t_irq();
      wr(CMPST_IRQ_MASK_OFS, 32'h0000_0000);
      cmp_raw <= 4'h1;
      cyc_wait(8);
      chk_bit(irq, 1'b0);
      wr(CMPST_IRQ_MASK_OFS, 32'h0000_0001);
      cyc_wait(2);
      chk_bit(irq, 1'b1);
      wr(CMPST_IRQ_STAT_OFS, 32'h0000_0001);
      cyc_wait(2);
      chk_bit(irq, 1'b0);
      $display("test irq done");
   endtask : t_irq
   task automatic t_idle();
      settle();
      wr(CMPST_STATUS_OFS, 32'h0000_8000);
      idle_mode <= 1'b1;
      cyc_wait(6);
      cmp_raw <= 4'hF;
      cyc_wait(8);
      rd_chk(CMPST_STATUS_OFS, 32'h0000_8000);
      idle_mode <= 1'b0;
      cyc_wait(8);
      rd_chk(CMPST_STATUS_OFS, 32'h0000_800F);
      wr(CMPST_STATUS_OFS, 32'h0000_0000);
      idle_mode <= 1'b1;
      cyc_wait(6);
      cmp_raw <= 4'h0;
      cyc_wait(8);
      rd_chk(CMPST_STATUS_OFS, 32'h0000_0000);
      idle_mode <= 1'b0;
      $display("test idle done");
   endtask : t_idle
   // ==========================================================
   // main sequence
   initial begin
      cyc_wait(12);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_write_mask();
      t_result();
      t_events();
      t_irq();
      t_idle();
      print_verdict();
   end
endmodule : tb_cmpst_top
`default_nettype wire
